// file: rtl/dic_pkg.sv
// constants for the init and command spacing controller
package dic_pkg;
    localparam int STAB_TIME_US   = 200;
    localparam int CLK_FREQ_MHZ   = 20;
    localparam int STAB_CYC       = STAB_TIME_US * CLK_FREQ_MHZ;
    localparam int INIT_IDLES     = 1024;
    localparam int N_BANKS        = 8;
    localparam int DUMMY_SETS     = 2;
    localparam int WR_RD_GAP      = 2;
    localparam int DLL_BIT        = 7;
    localparam int CFG_LOW_BITS   = 10;
    localparam int CNT_W          = 12;
    // pin command code {cs_n, we_n, ref_n}
    localparam logic [2:0] CMD_IDLE     = 3'h7;
    localparam logic [2:0] CMD_MODE_SET = 3'h0;
    localparam logic [2:0] CMD_READ     = 3'h3;
    localparam logic [2:0] CMD_WRITE    = 3'h1;
    localparam logic [2:0] CMD_REFRESH  = 3'h2;
    // user request kinds
    localparam logic [1:0] OP_READ      = 2'h0;
    localparam logic [1:0] OP_WRITE     = 2'h1;
    localparam logic [1:0] OP_REFRESH   = 2'h2;
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
    typedef enum logic [3:0] {
        DIC_WAIT    = 4'h0,
        DIC_MSET_D  = 4'h1,
        DIC_MSET_V  = 4'h3,
        DIC_SETTLE  = 4'h2,
        DIC_REF     = 4'h6,
        DIC_IDLES   = 4'h7,
        DIC_RUN     = 4'h5,
        DIC_DLL_OFF = 4'h4,
        DIC_DLL_SET = 4'hC,
        DIC_DLL_ON  = 4'hD
    } dic_st_e;
endpackage

// file: rtl/dic_ctrl.sv
// host-side power-up sequencer and command spacer for an eight-bank dram
// Functional notes
// - pins idle while waiting at power-up
// - hold stable 200 us before init
// - two dummy then one valid mode-set
// - init mode-sets go back to back
// - dummy mode-sets drive address all low
// - after settle refresh eight banks, 1024 idles
// - refreshes and idles may interleave freely
// - row cycle time after refresh, same bank
// - old 2048 idle spacing not required
// - upper address A10-A17 low on mode-set
// - clock change needs dll reset via mode-set
// - same-bank write to write waits row cycle
// - same-bank read to read waits row cycle
// - two idle slots between write and read
// - write latency is read latency plus one
`timescale 1ns/1ps
module dic_ctrl #(
    parameter int ADDR_W  = 18,
    parameter int DQ_W    = 18,
    parameter int RD_LAT  = 4,
    parameter int RC_CYC  = 8,
    parameter int MRSC_CYC = 6
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST,
    input  wire logic              I_REQ_VALID,
    input  wire logic [1:0]        I_REQ_OP,
    input  wire logic [2:0]        I_REQ_BANK,
    input  wire logic [ADDR_W-1:0] I_REQ_ADDR,
    input  wire logic [DQ_W-1:0]   I_REQ_WDATA,
    input  wire logic              I_REQ_WMASK,
    input  wire logic [9:0]        I_MODE_CFG,
    input  wire logic              I_DLL_RESET,
    input  wire logic [DQ_W-1:0]   I_DQ,
    input  wire logic              I_QVLD,
    output logic                   O_REQ_READY,
    output logic                   O_INIT_DONE,
    output logic [DQ_W-1:0]        O_RDATA,
    output logic                   O_RDATA_VALID,
    output logic                   O_CS_N,
    output logic                   O_WE_N,
    output logic                   O_REF_N,
    output logic [ADDR_W-1:0]      O_ADDR,
    output logic [2:0]             O_BA,
    output logic [DQ_W-1:0]        O_DQ,
    output logic                   O_DQ_OE,
    output logic                   O_WR_MASK
);
    localparam int WR_LAT = RD_LAT + 1;

    typedef struct packed {
        dic_pkg::dic_st_e              st;
        logic [dic_pkg::CNT_W-1:0]     cnt;
        logic [2:0]                    bank;
        logic [7:0][3:0]               rc;
        logic [1:0]                    gap;
        logic [WR_LAT-1:0]             wv;
        logic [WR_LAT-1:0][DQ_W:0]     wd;
        logic [2:0]                    cmd;
        logic [ADDR_W-1:0]             addr;
        logic [2:0]                    ba;
        logic [DQ_W-1:0]               dq;
        logic                          dq_oe;
        logic                          wmask;
        logic [DQ_W-1:0]               dq_s1;
        logic [DQ_W-1:0]               dq_s2;
        logic                          qv_s1;
        logic                          qv_s2;
        logic [DQ_W-1:0]               rdata;
        logic                          rvalid;
    } dic_state_s;

    dic_state_s q;
    dic_state_s d;
    logic       take;

    // upper bits forced low, the low config field reaches the pins with bit 7 set from dll_on
    function automatic logic [ADDR_W-1:0] mode_word(input logic [9:0] cfg,
                                                     input logic dll_on);
        logic [ADDR_W-1:0] w;
        w = '0;
        w[dic_pkg::CFG_LOW_BITS-1:0] = cfg;
        w[dic_pkg::DLL_BIT] = dll_on;
        return w;
    endfunction

    function automatic logic bank_free(input logic [7:0][3:0] rc,
                                       input logic [2:0] b);
        return rc[b] == 4'h0;
    endfunction

    // dll reset request wins over traffic so the clock change is settled first
    always_comb begin
        O_REQ_READY = (q.st == dic_pkg::DIC_RUN) && !I_DLL_RESET
                    && bank_free(q.rc, I_REQ_BANK)
                    && !(I_REQ_OP == dic_pkg::OP_READ && q.gap != 2'h0);
    end
    assign take = O_REQ_READY && I_REQ_VALID;

    always_comb begin
        d = q;
        d.cmd = dic_pkg::CMD_IDLE;
        d.addr = '0;
        d.ba = 3'h0;
        d.dq_s1 = I_DQ;
        d.dq_s2 = q.dq_s1;
        d.qv_s1 = I_QVLD;
        d.qv_s2 = q.qv_s1;
        d.rvalid = q.qv_s2;
        if (q.qv_s2) begin
            d.rdata = q.dq_s2;
        end
        for (int i = 0; i < dic_pkg::N_BANKS; i++) begin
            if (q.rc[i] != 4'h0) begin
                d.rc[i] = q.rc[i] - 4'h1;
            end
        end
        if (q.gap != 2'h0) begin
            d.gap = q.gap - 2'h1;
        end
        // write data leaves the pipe tail write_latency cycles after its command
        d.wv = q.wv >> 1;
        d.wd = q.wd >> (DQ_W + 1);
        d.dq_oe = q.wv[0];
        d.dq = q.wd[0][DQ_W-1:0];
        d.wmask = q.wv[0] & q.wd[0][DQ_W];
        case (q.st)
            dic_pkg::DIC_WAIT: begin
                d.cnt = q.cnt + 12'h001;
                if (q.cnt == 12'(dic_pkg::STAB_CYC - 1)) begin
                    d.st = dic_pkg::DIC_MSET_D;
                    d.cnt = dic_pkg::CNT_RST;
                end
            end
            dic_pkg::DIC_MSET_D: begin
                d.cmd = dic_pkg::CMD_MODE_SET;
                d.addr = '0;
                d.cnt = q.cnt + 12'h001;
                if (q.cnt == 12'(dic_pkg::DUMMY_SETS - 1)) begin
                    d.st = dic_pkg::DIC_MSET_V;
                end
            end
            dic_pkg::DIC_MSET_V: begin
                d.cmd = dic_pkg::CMD_MODE_SET;
                d.addr = mode_word(I_MODE_CFG, I_MODE_CFG[dic_pkg::DLL_BIT]);
                d.st = dic_pkg::DIC_SETTLE;
                d.cnt = dic_pkg::CNT_RST;
            end
            dic_pkg::DIC_SETTLE: begin
                d.cnt = q.cnt + 12'h001;
                if (q.cnt == 12'(MRSC_CYC - 1)) begin
                    d.st = dic_pkg::DIC_REF;
                    d.cnt = dic_pkg::CNT_RST;
                    d.bank = 3'h0;
                end
            end
            dic_pkg::DIC_REF: begin
                // all refreshes first, then the idles; order is free
                d.cmd = dic_pkg::CMD_REFRESH;
                d.ba = q.bank;
                d.rc[q.bank] = 4'(RC_CYC - 1);
                d.bank = q.bank + 3'h1;
                if (q.bank == 3'h7) begin
                    d.st = dic_pkg::DIC_IDLES;
                    d.cnt = dic_pkg::CNT_RST;
                end
            end
            dic_pkg::DIC_IDLES: begin
                d.cnt = q.cnt + 12'h001;
                if (q.cnt == 12'(dic_pkg::INIT_IDLES - 1)) begin
                    d.st = dic_pkg::DIC_RUN;
                end
            end
            dic_pkg::DIC_RUN: begin
                if (I_DLL_RESET) begin
                    d.st = dic_pkg::DIC_DLL_OFF;
                end else if (take) begin
                    d.ba = I_REQ_BANK;
                    d.rc[I_REQ_BANK] = 4'(RC_CYC - 1);
                    if (I_REQ_OP == dic_pkg::OP_WRITE) begin
                        d.cmd = dic_pkg::CMD_WRITE;
                        d.addr = I_REQ_ADDR;
                        d.gap = 2'(dic_pkg::WR_RD_GAP);
                        d.wv[WR_LAT-1] = 1'b1;
                        d.wd[WR_LAT-1] = {I_REQ_WMASK, I_REQ_WDATA};
                    end else if (I_REQ_OP == dic_pkg::OP_READ) begin
                        d.cmd = dic_pkg::CMD_READ;
                        d.addr = I_REQ_ADDR;
                    end else begin
                        d.cmd = dic_pkg::CMD_REFRESH;
                    end
                end
            end
            dic_pkg::DIC_DLL_OFF: begin
                d.cmd = dic_pkg::CMD_MODE_SET;
                d.addr = mode_word(I_MODE_CFG, 1'b0);
                d.st = dic_pkg::DIC_DLL_SET;
                d.cnt = dic_pkg::CNT_RST;
            end
            dic_pkg::DIC_DLL_SET: begin
                d.cnt = q.cnt + 12'h001;
                if (q.cnt == 12'(MRSC_CYC - 1)) begin
                    d.st = dic_pkg::DIC_DLL_ON;
                end
            end
            dic_pkg::DIC_DLL_ON: begin
                // 1024 idles also cover the lock time before a read
                d.cmd = dic_pkg::CMD_MODE_SET;
                d.addr = mode_word(I_MODE_CFG, 1'b1);
                d.st = dic_pkg::DIC_IDLES;
                d.cnt = dic_pkg::CNT_RST;
            end
            default: begin
                d.st = dic_pkg::DIC_WAIT;
                d.cnt = dic_pkg::CNT_RST;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            q <= '0;
            q.cmd <= dic_pkg::CMD_IDLE;
        end else begin
            q <= d;
        end
    end

    assign O_INIT_DONE   = (q.st == dic_pkg::DIC_RUN);
    assign O_RDATA       = q.rdata;
    assign O_RDATA_VALID = q.rvalid;
    assign O_CS_N        = q.cmd[2];
    assign O_WE_N        = q.cmd[1];
    assign O_REF_N       = q.cmd[0];
    assign O_ADDR        = q.addr;
    assign O_BA          = q.ba;
    assign O_DQ          = q.dq;
    assign O_DQ_OE       = q.dq_oe;
    assign O_WR_MASK     = q.wmask;

    // helper: cycles since the last pin command to each bank, saturating
    logic [7:0][4:0] since_q;
    logic            bank_cmd;
    assign bank_cmd = (q.cmd == dic_pkg::CMD_READ) || (q.cmd == dic_pkg::CMD_WRITE)
                   || (q.cmd == dic_pkg::CMD_REFRESH);
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            since_q <= {8{5'h1F}};
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (bank_cmd && q.ba == 3'(i)) begin
                    since_q[i] <= 5'h1;
                end else if (since_q[i] != 5'h1F) begin
                    since_q[i] <= since_q[i] + 5'h1;
                end
            end
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    sequence s_three_msets;
        (q.cmd == dic_pkg::CMD_MODE_SET) [*3] ##1 (q.cmd == dic_pkg::CMD_IDLE);
    endsequence
    sequence s_eight_refs;
        (q.cmd == dic_pkg::CMD_REFRESH) [*8] ##1 (q.cmd == dic_pkg::CMD_IDLE);
    endsequence

    a_wait_pins_idle: assert property (q.st == dic_pkg::DIC_WAIT |-> q.cmd == dic_pkg::CMD_IDLE)
        else $error("command pins not idle during power-up wait");
    a_stab_wait_len: assert property ((q.st == dic_pkg::DIC_MSET_D && q.cnt == 12'h000)
        |-> $past(q.cnt) == 12'(dic_pkg::STAB_CYC - 1))
        else $error("init started before the stability wait ended");
    a_mode_run_three: assert property ((q.st == dic_pkg::DIC_MSET_D && q.cnt == 12'h000)
        |=> s_three_msets)
        else $error("init mode-set run is not three back to back");
    a_dummy_addr_low: assert property ((q.cmd == dic_pkg::CMD_MODE_SET
        && $past(q.st) == dic_pkg::DIC_MSET_D) |-> q.addr == '0)
        else $error("dummy mode-set address not low");
    a_mode_upper_low: assert property (q.cmd == dic_pkg::CMD_MODE_SET
        |-> q.addr[ADDR_W-1:dic_pkg::CFG_LOW_BITS] == '0)
        else $error("mode-set upper address bits not low");
    a_init_refresh: assert property ($rose(q.st == dic_pkg::DIC_REF) |=> s_eight_refs)
        else $error("init refresh burst wrong");
    // the count of the bank on the pins now, not the bank of the cycle before
    a_bank_row_cycle: assert property (bank_cmd |-> since_q[q.ba] >= 5'(RC_CYC))
        else $error("same bank command before row cycle time");
    a_wr_rd_gap: assert property (q.cmd == dic_pkg::CMD_WRITE
        |=> (q.cmd != dic_pkg::CMD_READ) [*2])
        else $error("read too soon after write");
    a_wdata_lat: assert property (q.cmd == dic_pkg::CMD_WRITE |-> ##WR_LAT q.dq_oe)
        else $error("write data not at write latency");
    a_ready_after: assert property ($rose(q.st == dic_pkg::DIC_RUN)
        |-> $past(q.cnt) == 12'(dic_pkg::INIT_IDLES - 1))
        else $error("ready before 1024 idles");
endmodule

// file: dv/dic_dev_model.sv
// behavioural eight-bank memory device that judges the pin traffic
`timescale 1ns/1ps
module dic_dev_model #(
    parameter int ADDR_W   = 18,
    parameter int DQ_W     = 18,
    parameter int RD_LAT   = 4,
    parameter int RC_CYC   = 8,
    parameter int MRSC_CYC = 6
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic [2:0]        i_cmd,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [2:0]        i_ba,
    input  wire logic [DQ_W-1:0]   i_dq,
    input  wire logic              i_dq_oe,
    input  wire logic              i_wr_mask,
    output logic [DQ_W-1:0]        o_dq,
    output logic                   o_qvld,
    output int                     o_viol,
    output int                     o_dll_off,
    output int                     o_dll_on,
    output logic [ADDR_W-1:0]      o_mode_word,
    output logic [7:0]             o_ref_mask
);
    int                cyc, last_mset, last_wr, idl, mrun, key, s;
    int                bank_t [8];
    int                wr_key [16];
    int                rd_key [16];
    bit                wr_due [16];
    bit                rd_due [16];
    bit                started, inited;
    logic [ADDR_W-1:0] prev_addr;
    logic [DQ_W-1:0]   mem [int];
    initial o_viol = 0;
    always @(posedge i_clock) begin
        key = int'({i_ba, i_addr[9:0]});
        if (i_rst) begin
            cyc = 0;
            started = 0;
            inited = 0;
            mrun = 0;
            idl = 0;
            last_wr = -100;
            last_mset = -100;
            o_dll_off = 0;
            o_dll_on = 0;
            o_ref_mask = 8'h00;
            o_qvld <= 1'b0;
            foreach (bank_t[b]) bank_t[b] = -100;
            foreach (wr_due[i]) begin
                wr_due[i] = 0;
                rd_due[i] = 0;
            end
        end else begin
            cyc++;
            s = cyc % 16;
            if (wr_due[s]) begin
                if (i_dq_oe !== 1'b1) o_viol++;
                else if (i_wr_mask === 1'b0) mem[wr_key[s]] = i_dq;
                wr_due[s] = 0;
            end else if (i_dq_oe !== 1'b0) o_viol++;
            // released read bus flips to its inverse each cycle, so a stale word shows every second cycle
            o_qvld <= rd_due[s];
            o_dq <= rd_due[s] ? (mem.exists(rd_key[s]) ? mem[rd_key[s]] : '0) : ~o_dq;
            rd_due[s] = 0;
            if (i_cmd != dic_pkg::CMD_MODE_SET && mrun > 0 && !inited) begin
                if (mrun < 3) o_viol++;
                else inited = 1;
            end
            if (!started && i_cmd != dic_pkg::CMD_IDLE && i_cmd != dic_pkg::CMD_MODE_SET)
                o_viol++;
            case (i_cmd)
                dic_pkg::CMD_MODE_SET: begin
                    if (!started && cyc <= dic_pkg::STAB_CYC) o_viol++;
                    if (i_addr[ADDR_W-1:10] != '0) o_viol++;
                    if (mrun > 0 && prev_addr != '0) o_viol++;
                    if (mrun == 2) o_ref_mask = 8'h00;
                    if (inited && i_addr[7]) begin
                        if (cyc - last_mset < MRSC_CYC) o_viol++;
                        o_dll_on++;
                    end else if (inited) o_dll_off++;
                    started = 1;
                    mrun++;
                    last_mset = cyc;
                    idl = 0;
                    o_mode_word <= i_addr;
                end
                dic_pkg::CMD_REFRESH: begin
                    if (cyc - last_mset < MRSC_CYC) o_viol++;
                    if (cyc - bank_t[i_ba] < RC_CYC) o_viol++;
                    bank_t[i_ba] = cyc;
                    o_ref_mask[i_ba] = 1'b1;
                end
                dic_pkg::CMD_READ, dic_pkg::CMD_WRITE: begin
                    if (o_ref_mask != 8'hFF || idl < dic_pkg::INIT_IDLES) o_viol++;
                    if (cyc - bank_t[i_ba] < RC_CYC) o_viol++;
                    bank_t[i_ba] = cyc;
                    if (i_cmd == dic_pkg::CMD_WRITE) begin
                        wr_due[(cyc + RD_LAT + 1) % 16] = 1;
                        wr_key[(cyc + RD_LAT + 1) % 16] = key;
                        last_wr = cyc;
                    end else begin
                        if (cyc - last_wr < 3) o_viol++;
                        rd_due[(cyc + RD_LAT) % 16] = 1;
                        rd_key[(cyc + RD_LAT) % 16] = key;
                    end
                end
                default: idl++;
            endcase
            if (i_cmd != dic_pkg::CMD_MODE_SET) mrun = 0;
            prev_addr = i_addr;
        end
    end
endmodule

// file: dv/dic_ctrl_bench.sv
// self-checking bench for the init and command spacing controller
`timescale 1ns/1ps
module dic_ctrl_bench;
    localparam logic [9:0] CFG = 10'h0A5;
    localparam int         RC  = 8;
    logic        clk, rst, req_valid, req_wmask, dll_reset, qvld, dq_oe, wr_mask, rdata_valid;
    logic        ready, init_done, cs_n, we_n, ref_n;
    logic [1:0]  req_op;
    logic [2:0]  req_bank, ba;
    logic [17:0] req_addr, req_wdata, dq_in, rdata, addr, dq_out, mode_word;
    logic [7:0]  ref_mask;
    int          viol, dll_off, dll_on, wt;
    int          n_errors = 0;
    int          n_tests = 0;

    dic_ctrl #(.RC_CYC(RC)) i_dut (.I_CLOCK(clk), .I_RST(rst), .I_REQ_VALID(req_valid),
        .I_REQ_OP(req_op), .I_REQ_BANK(req_bank), .I_REQ_ADDR(req_addr),
        .I_REQ_WDATA(req_wdata), .I_REQ_WMASK(req_wmask), .I_MODE_CFG(CFG),
        .I_DLL_RESET(dll_reset), .I_DQ(dq_in), .I_QVLD(qvld), .O_REQ_READY(ready),
        .O_INIT_DONE(init_done), .O_RDATA(rdata), .O_RDATA_VALID(rdata_valid),
        .O_CS_N(cs_n), .O_WE_N(we_n), .O_REF_N(ref_n), .O_ADDR(addr), .O_BA(ba),
        .O_DQ(dq_out), .O_DQ_OE(dq_oe), .O_WR_MASK(wr_mask));
    dic_dev_model #(.RC_CYC(RC)) i_dev (.i_clock(clk), .i_rst(rst),
        .i_cmd({cs_n, we_n, ref_n}), .i_addr(addr), .i_ba(ba), .i_dq(dq_out),
        .i_dq_oe(dq_oe), .i_wr_mask(wr_mask), .o_dq(dq_in), .o_qvld(qvld), .o_viol(viol),
        .o_dll_off(dll_off), .o_dll_on(dll_on), .o_mode_word(mode_word),
        .o_ref_mask(ref_mask));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            n_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    // held until taken; wt ends as the edges spent waiting for ready
    task automatic req(input logic [1:0] op, input logic [2:0] b, input logic [17:0] a,
                       input logic [17:0] d, input logic m);
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_bank = b;
        req_addr = a;
        req_wdata = d;
        req_wmask = m;
        wt = 0;
        do begin
            @(posedge clk);
            wt++;
        end while (ready !== 1'b1 && wt < 60);
        check(wt < 60, "request never taken");
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    task automatic wait_rd(input logic [17:0] exp);
        int n;
        n = 0;
        while (rdata_valid !== 1'b1 && n < 30) begin
            @(negedge clk);
            n++;
        end
        check(n < 30 && rdata === exp, "read data wrong");
    endtask

    task automatic t_init();
        int n;
        n = 0;
        while (cs_n === 1'b1 && n < 4100) begin
            @(negedge clk);
            n++;
        end
        check(n >= dic_pkg::STAB_CYC && n <= dic_pkg::STAB_CYC + 3, "init start");
        check(we_n === 1'b0 && ref_n === 1'b0 && addr === '0, "dummy mode-set");
        check(ready === 1'b0 && init_done === 1'b0, "ready during init");
        n = 0;
        while (init_done !== 1'b1 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        check(n >= 1024 + 8 + 3 && n <= 1048, "init length");
        check(ref_mask === 8'hFF && mode_word === {8'h00, CFG}, "init content");
    endtask

    task automatic t_traffic();
        req(dic_pkg::OP_WRITE, 3'h1, 18'h00005, 18'h2A5C3, 1'b0);
        req(dic_pkg::OP_WRITE, 3'h1, 18'h00006, 18'h15A3C, 1'b0);
        check(wt >= RC - 1, "write to write same bank");
        req(dic_pkg::OP_READ, 3'h3, 18'h00001, 18'h00000, 1'b0);
        check(wt >= 2, "read too close to write");
        wait_rd(18'h00000);
        req(dic_pkg::OP_READ, 3'h1, 18'h00005, 18'h00000, 1'b0);
        req(dic_pkg::OP_READ, 3'h1, 18'h00006, 18'h00000, 1'b0);
        check(wt >= RC - 1, "read to read same bank");
        // first word is up as the second read is taken; skip past it for the second
        wait_rd(18'h2A5C3);
        @(negedge clk);
        wait_rd(18'h15A3C);
        req(dic_pkg::OP_WRITE, 3'h2, 18'h00007, 18'h0F0F0, 1'b0);
        req(dic_pkg::OP_WRITE, 3'h5, 18'h00007, 18'h3FFFF, 1'b0);
        check(wt < 3, "other bank held back");
        req(dic_pkg::OP_WRITE, 3'h2, 18'h00007, 18'h33333, 1'b1);
        req(dic_pkg::OP_REFRESH, 3'h2, 18'h3FFFF, 18'h00000, 1'b0);
        check(wt >= RC - 1, "refresh after write same bank");
        req(dic_pkg::OP_READ, 3'h2, 18'h00007, 18'h00000, 1'b0);
        check(wt >= RC - 1, "read after refresh same bank");
        wait_rd(18'h0F0F0);
    endtask

    task automatic t_dll();
        int n;
        @(negedge clk);
        dll_reset = 1'b1;
        n = 0;
        while (init_done !== 1'b0 && n < 10) begin
            @(negedge clk);
            n++;
        end
        dll_reset = 1'b0;
        check(n < 10 && ready === 1'b0, "dll reset not started");
        n = 0;
        while (init_done !== 1'b1 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        check(n >= 1024 && dll_off === 1 && dll_on === 1, "dll reset sequence");
        req(dic_pkg::OP_READ, 3'h1, 18'h00006, 18'h00000, 1'b0);
        wait_rd(18'h15A3C);
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = 2'h0;
        req_bank = 3'h0;
        req_addr = '0;
        req_wdata = '0;
        req_wmask = 1'b0;
        dll_reset = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_init();
        t_traffic();
        t_dll();
        repeat (20) @(negedge clk);
        check(viol === 0, "device saw a timing breach");
        complete_run();
    end

    // whole run is near 6200 cycles
    initial begin
        repeat (12000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
